// *** verilog/ccpo_compare.sv ***
// four compare channels with pin actions, pin pairing and transaction server
// How it works
// - on reference timer equal event time, drive pin high, low or invert
// - with repeat_on_match set, act again on every later match
// - with repeat_on_match clear, act once; rearm on event time write
// - toggle with repeat inverts pin and raises interrupt each match
// - pin_pairing_bit of channel 1 or 3 routes lower channel onto its pin
// - paired match with server on adds period constant to event time
// - set and clear times one count apart give a one-count pulse
// - first channel of a pair toggles the pin on dedicated timer match
// - second channel toggles the same pin and resets the timer
// - compare events are at least one prescaled tick apart, 200 ns min
// - timer_two_clock_pin in use takes pin of channel 0 away
// - timer_two_direction_pin in use takes pin of channel 1 away
// - a timer used by server pwm never gets reset by channels
// - action_field 00 none, 01 low, 10 high, 11 invert
// - reference_timer_select 0 picks timer 1, 1 picks timer 2
// - compare select 0 capture, 1 compare
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
module ccpo_compare (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic timerTwoClockPin,
  input wire logic timerTwoDirectionPin,
  output logic [3:0] chanPin,
  output logic [3:0] chanPinEn,
  output logic irq
);
  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic [15:0] ctl_q [4];
  logic [15:0] evTime_q [4];
  logic [15:0] timer_q [2];
  logic [7:0] tctl_q [2];
  logic [3:0] stat_q;
  logic [3:0] mask_q;
  logic [15:0] period_q;
  logic [3:0] armed_q;
  logic [3:0] pin_q;
  logic [1:0] refUpd_q;
  logic [2:0] clkSync_q;
  logic [1:0] dirSync_q;
  logic [3:0] baseCnt_q;
  logic [6:0] pre_q;
  logic baseTick;
  logic clkEdge;
  logic [1:0] tick;
  logic [1:0] countUp;
  logic [3:0] hit;
  logic [1:0] pairOn;
  logic [1:0] tsOn;
  logic [1:0] pwmUses;
  logic [1:0] timerRst;
  logic [3:0] pin_d;

  // prescaler tap: true on every 2^p-th base step
  function automatic logic preTick(input logic [6:0] cnt, input logic [2:0] p);
    logic [7:0] m;
    m = (8'h01 << p) - 8'h01;
    return (cnt & m[6:0]) == 7'h00;
  endfunction

  // new pin level for one action
  function automatic logic applyAct(input logic v, input logic [1:0] a);
    case (a)
      ccpo_pkg::ACT_LOW: applyAct = 1'b0;
      ccpo_pkg::ACT_HIGH: applyAct = 1'b1;
      ccpo_pkg::ACT_TOGGLE: applyAct = ~v;
      default: applyAct = v;
    endcase
  endfunction

  // --------------------------------------------------------------
  // pin inputs and prescaler
  // --------------------------------------------------------------
  // two flops before use; third stage only feeds edge detect
  always_ff @(posedge clk) begin
    if (!nrst) begin
      clkSync_q <= 3'h0;
      dirSync_q <= 2'h0;
    end else begin
      clkSync_q <= {clkSync_q[1:0], timerTwoClockPin};
      dirSync_q <= {dirSync_q[0], timerTwoDirectionPin};
    end
  end
  assign clkEdge = clkSync_q[1] & ~clkSync_q[2];

  // base step never shorter than the least resolution
  always_ff @(posedge clk) begin
    if (!nrst) begin
      baseCnt_q <= 4'h0;
      pre_q <= 7'h00;
    end else if (baseTick) begin
      baseCnt_q <= 4'h0;
      pre_q <= pre_q + 7'h01;
    end else begin
      baseCnt_q <= baseCnt_q + 4'h1;
    end
  end
  assign baseTick = baseCnt_q == 4'(ccpo_pkg::BASE_CYCLES - 1);

  always_comb begin
    tick[0] = tctl_q[0][ccpo_pkg::TC_EN] & baseTick & preTick(pre_q, tctl_q[0][2:0]);
    tick[1] = tctl_q[1][ccpo_pkg::TC_EN] & (tctl_q[1][ccpo_pkg::TC_XCLK] ? clkEdge :
              baseTick & preTick(pre_q, tctl_q[1][2:0]));
    countUp[0] = tctl_q[0][ccpo_pkg::TC_UP];
    countUp[1] = tctl_q[1][ccpo_pkg::TC_XDIR] ? dirSync_q[1] : tctl_q[1][ccpo_pkg::TC_UP];
  end

  // --------------------------------------------------------------
  // match, timer reset and pin routing
  // --------------------------------------------------------------
  // compare only in the cycle after a count step, so one hit per count
  always_comb begin
    pairOn[0] = ctl_q[1][ccpo_pkg::CTL_PAIR];
    pairOn[1] = ctl_q[3][ccpo_pkg::CTL_PAIR];
    for (int p = 0; p < 2; p++) begin
      tsOn[p] = pairOn[p] & (period_q != 16'h0000);
      pwmUses[p] = 1'b0;
    end
    for (int i = 0; i < ccpo_pkg::NCH; i++) begin
      hit[i] = ctl_q[i][ccpo_pkg::CTL_CMP] & armed_q[i]
             & refUpd_q[ctl_q[i][ccpo_pkg::CTL_REF]]
             & (timer_q[ctl_q[i][ccpo_pkg::CTL_REF]] == evTime_q[i]);
      if (tsOn[i >> 1] && ctl_q[i][ccpo_pkg::CTL_CMP])
        pwmUses[ctl_q[i][ccpo_pkg::CTL_REF]] = 1'b1;
    end
    for (int t = 0; t < 2; t++) begin
      timerRst[t] = 1'b0;
      for (int i = 0; i < ccpo_pkg::NCH; i++) begin
        if (hit[i] && ctl_q[i][ccpo_pkg::CTL_RST] &&
            ((ctl_q[i][ccpo_pkg::CTL_REF] ^ ctl_q[i][ccpo_pkg::CTL_ROT]) == 1'(t)))
          timerRst[t] = 1'b1;
      end
      // a server-driven timer keeps running whatever others ask
      if (pwmUses[t])
        timerRst[t] = 1'b0;
    end
  end

  // paired lower channel acts on the upper channel's pin
  always_comb begin
    pin_d = pin_q;
    for (int c = 0; c < ccpo_pkg::NCH; c++) begin
      if (hit[c]) begin
        if (c % 2 == 0 && pairOn[c >> 1])
          pin_d[c | 1] = applyAct(pin_d[c | 1], ctl_q[c][5:4]);
        else
          pin_d[c] = applyAct(pin_d[c], ctl_q[c][5:4]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      pin_q <= ccpo_pkg::RST_NIB;
    else
      pin_q <= pin_d;
  end
  assign chanPin = pin_q;

  // pin free when channel is idle, paired away or lent to timer 2
  assign chanPinEn[0] = ctl_q[0][ccpo_pkg::CTL_CMP] & ~pairOn[0]
                      & ~tctl_q[1][ccpo_pkg::TC_XCLK];
  assign chanPinEn[1] = (ctl_q[1][ccpo_pkg::CTL_CMP] | (pairOn[0] & ctl_q[0][ccpo_pkg::CTL_CMP]))
                      & ~tctl_q[1][ccpo_pkg::TC_XDIR];
  assign chanPinEn[2] = ctl_q[2][ccpo_pkg::CTL_CMP] & ~pairOn[1];
  assign chanPinEn[3] = ctl_q[3][ccpo_pkg::CTL_CMP] | (pairOn[1] & ctl_q[2][ccpo_pkg::CTL_CMP]);

  // --------------------------------------------------------------
  // timers
  // --------------------------------------------------------------
  // software load beats channel reset beats counting
  always_ff @(posedge clk) begin
    if (!nrst) begin
      timer_q[0] <= ccpo_pkg::RST_WORD;
      timer_q[1] <= ccpo_pkg::RST_WORD;
      refUpd_q <= 2'h0;
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (regWr && regAddr == 4'(ccpo_pkg::ADDR_TMR1 + t))
          timer_q[t] <= regWdata;
        else if (timerRst[t])
          timer_q[t] <= 16'h0000;
        else if (tick[t])
          timer_q[t] <= countUp[t] ? timer_q[t] + 16'h0001 : timer_q[t] - 16'h0001;
      end
      refUpd_q <= tick;
    end
  end

  // --------------------------------------------------------------
  // channel registers and transaction server
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < ccpo_pkg::NCH; i++) begin
        ctl_q[i] <= ccpo_pkg::RST_WORD;
        evTime_q[i] <= ccpo_pkg::RST_WORD;
      end
      armed_q <= ccpo_pkg::RST_NIB;
    end else begin
      for (int i = 0; i < ccpo_pkg::NCH; i++) begin
        if (regWr && regAddr == 4'(ccpo_pkg::ADDR_CTL0 + i))
          ctl_q[i] <= regWdata & ((i % 2 == 1) ? ccpo_pkg::CTL_WMASK_ODD :
                                  ccpo_pkg::CTL_WMASK_EVEN);
        // a software write rearms; it wins over the hit in the same cycle
        if (regWr && regAddr == 4'(ccpo_pkg::ADDR_TIME0 + i)) begin
          evTime_q[i] <= regWdata;
          armed_q[i] <= 1'b1;
        end else if (hit[i]) begin
          if (tsOn[i >> 1])
            evTime_q[i] <= evTime_q[i] + period_q;
          if (!ctl_q[i][ccpo_pkg::CTL_REP])
            armed_q[i] <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // interrupts and misc registers
  // --------------------------------------------------------------
  // a hit in the clearing read's cycle survives
  always_ff @(posedge clk) begin
    if (!nrst)
      stat_q <= ccpo_pkg::RST_NIB;
    else
      stat_q <= ((regRd && regAddr == ccpo_pkg::ADDR_STAT) ? 4'h0 : stat_q) | hit;
  end
  assign irq = |(stat_q & mask_q);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mask_q <= ccpo_pkg::RST_NIB;
      period_q <= ccpo_pkg::RST_WORD;
      tctl_q[0] <= ccpo_pkg::RST_TCTL;
      tctl_q[1] <= ccpo_pkg::RST_TCTL;
    end else if (regWr) begin
      if (regAddr == ccpo_pkg::ADDR_MASK)
        mask_q <= regWdata[3:0];
      if (regAddr == ccpo_pkg::ADDR_PERIOD)
        period_q <= regWdata;
      for (int t = 0; t < 2; t++)
        if (regAddr == 4'(ccpo_pkg::ADDR_TCTL1 + t))
          tctl_q[t] <= regWdata[7:0] & ccpo_pkg::TC_WMASK;
    end
  end

  // read data stand one cycle, zero otherwise and for unmapped addresses
  always_ff @(posedge clk) begin
    if (!nrst) begin
      regRdata <= 16'h0000;
    end else begin
      regRdata <= 16'h0000;
      if (regRd) begin
        case (regAddr)
          4'h0, 4'h1, 4'h2, 4'h3: regRdata <= ctl_q[regAddr[1:0]];
          4'h4, 4'h5, 4'h6, 4'h7: regRdata <= evTime_q[regAddr[1:0]];
          4'h8, 4'h9: regRdata <= timer_q[regAddr[0]];
          4'ha, 4'hb: regRdata <= {8'h00, tctl_q[regAddr[0]]};
          ccpo_pkg::ADDR_STAT: regRdata <= {12'h000, stat_q};
          ccpo_pkg::ADDR_MASK: regRdata <= {12'h000, mask_q};
          ccpo_pkg::ADDR_PERIOD: regRdata <= period_q;
          default: regRdata <= 16'h0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_toggle;
    hit[2] && !pairOn[1] && ctl_q[2][5:4] == 2'h3 |=> chanPin[2] != $past(chanPin[2]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle match did not invert");
  property p_low;
    hit[0] && !pairOn[0] && ctl_q[0][5:4] == 2'h1 |=> !chanPin[0];
  endproperty
  a_low: assert property (p_low) else $error("clear action left pin high");
  property p_once;
    hit[0] && !ctl_q[0][ccpo_pkg::CTL_REP] && !regWr |=> !armed_q[0] ##1 !hit[0];
  endproperty
  a_once: assert property (p_once) else $error("single-shot channel rearmed");
  property p_repeat;
    hit[1] && ctl_q[1][ccpo_pkg::CTL_REP] && !regWr |=> armed_q[1];
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat channel disarmed");
  property p_irq;
    hit[3] |=> stat_q[3];
  endproperty
  a_irq: assert property (p_irq) else $error("match raised no status");
  property p_server;
    hit[0] && tsOn[0] && !regWr |=> evTime_q[0] == $past(evTime_q[0]) + $past(period_q);
  endproperty
  a_server: assert property (p_server) else $error("period not added");
  property p_once_per_count;
    hit[0] |=> !hit[0];
  endproperty
  a_once_per_count: assert property (p_once_per_count) else $error("double hit");
  property p_step;
    tick[0] |=> !tick[0];
  endproperty
  a_step: assert property (p_step) else $error("timer stepped too fast");
  property p_timer_two_clock_pin;
    tctl_q[1][ccpo_pkg::TC_XCLK] |-> !chanPinEn[0];
  endproperty
  a_timer_two_clock_pin: assert property (p_timer_two_clock_pin) else $error("channel 0 pin not released");
  property p_timer_two_direction_pin;
    tctl_q[1][ccpo_pkg::TC_XDIR] |-> !chanPinEn[1];
  endproperty
  a_timer_two_direction_pin: assert property (p_timer_two_direction_pin) else $error("channel 1 pin not released");
  property p_pair;
    pairOn[0] |-> !chanPinEn[0];
  endproperty
  a_pair: assert property (p_pair) else $error("paired lower pin still driven");
  // a down count may pass through zero legally, so only up counting is watched
  property p_keep;
    pwmUses[0] && countUp[0] && !regWr && tick[0]
      |=> timer_q[0] != 16'h0000 || $past(timer_q[0]) == 16'hffff;
  endproperty
  a_keep: assert property (p_keep) else $error("server timer was reset");

  c_toggle: cover property (hit[2] && ctl_q[2][5:4] == 2'h3 && ctl_q[2][ccpo_pkg::CTL_REP]);
  c_paired: cover property (hit[0] && tsOn[0]);
  c_reset: cover property (timerRst[0]);
endmodule

// *** pkg/ccpo_pkg.sv ***
// constants for the four-channel compare and pwm output block
package ccpo_pkg;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int MIN_STEP_NS = 160;
  // least step rounds up to whole cycles
  localparam int BASE_CYCLES = (MIN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NCH = 4;
  localparam int DW = 16;
  // --------------------------------------------------------------
  // register addresses
  // --------------------------------------------------------------
  localparam logic [3:0] ADDR_CTL0 = 4'h0;
  localparam logic [3:0] ADDR_TIME0 = 4'h4;
  localparam logic [3:0] ADDR_TMR1 = 4'h8;
  localparam logic [3:0] ADDR_TCTL1 = 4'ha;
  localparam logic [3:0] ADDR_STAT = 4'hc;
  localparam logic [3:0] ADDR_MASK = 4'hd;
  localparam logic [3:0] ADDR_PERIOD = 4'he;
  // --------------------------------------------------------------
  // channel_control fields
  // --------------------------------------------------------------
  localparam int CTL_PAIR = 8;
  localparam int CTL_REF = 7;
  localparam int CTL_CMP = 6;
  localparam int CTL_ACT = 4;
  localparam int CTL_REP = 3;
  localparam int CTL_ROT = 1;
  localparam int CTL_RST = 0;
  localparam logic [15:0] CTL_WMASK_EVEN = 16'h00fb;
  localparam logic [15:0] CTL_WMASK_ODD = 16'h01fb;
  // --------------------------------------------------------------
  // timer_control fields
  // --------------------------------------------------------------
  localparam int TC_EN = 7;
  localparam int TC_UP = 6;
  localparam int TC_XDIR = 4;
  localparam int TC_XCLK = 3;
  localparam logic [7:0] TC_WMASK = 8'hdf;
  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_TCTL = 8'h00;
  localparam logic [3:0] RST_NIB = 4'h0;
  // action_field encoding
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_LOW = 2'h1,
    ACT_HIGH = 2'h2,
    ACT_TOGGLE = 2'h3
  } ccpo_act_e;
endpackage

// *** tb/ccpo_pin_load.sv ***
// external load on the four channel pins: pull-down pads and pulse meters
module ccpo_pin_load (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] chanPin,
  input wire logic [3:0] chanPinEn,
  output logic [3:0] padLevel,
  output logic [3:0][15:0] riseCount,
  output logic [3:0][15:0] lastHigh
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0][15:0] runHigh;
  logic [3:0] padQ;
  // --------------------------------------------------------------
  // pads
  // --------------------------------------------------------------
  // a pad whose driver is off falls to the pull-down, never keeps its level
  assign padLevel = chanPin & chanPinEn;
  // --------------------------------------------------------------
  // meters
  // --------------------------------------------------------------
  // high width in clock cycles and count of rising edges, per pad
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!nrst) begin
        runHigh[i] <= 16'h0;
        lastHigh[i] <= 16'h0;
        riseCount[i] <= 16'h0;
        padQ[i] <= 1'b0;
      end else begin
        padQ[i] <= padLevel[i];
        if (padLevel[i]) begin
          runHigh[i] <= runHigh[i] + 16'h1;
        end else begin
          runHigh[i] <= 16'h0;
        end
        // width is latched on the falling edge only
        if (!padLevel[i] && padQ[i]) begin
          lastHigh[i] <= runHigh[i];
        end
        if (padLevel[i] && !padQ[i]) begin
          riseCount[i] <= riseCount[i] + 16'h1;
        end
      end
    end
  end
endmodule

// *** tb/compare_channel_pwm_output_tb.sv ***
// self-checking bench for the compare and pwm output block
module compare_channel_pwm_output_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] TMR2 = 4'h9;
  localparam logic [3:0] TCTL2 = 4'hb;
  localparam logic [15:0] BC = 16'(ccpo_pkg::BASE_CYCLES);
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdata;
  logic tTwoClk = 1'b0;
  logic tTwoDir = 1'b0;
  logic [3:0] chanPin;
  logic [3:0] chanPinEn;
  logic irq;
  logic [3:0] padLevel;
  logic [3:0][15:0] riseCount;
  logic [3:0][15:0] lastHigh;
  logic [15:0] d;
  int miscompares = 0;
  int n_compared = 0;

  ccpo_compare dut_u (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .timerTwoClockPin(tTwoClk),
    .timerTwoDirectionPin(tTwoDir), .chanPin(chanPin), .chanPinEn(chanPinEn), .irq(irq));
  ccpo_pin_load load_u (.clk(clk), .nrst(nrst), .chanPin(chanPin), .chanPinEn(chanPinEn),
    .padLevel(padLevel), .riseCount(riseCount), .lastHigh(lastHigh));

  // 10 MHz core clock
  always #50 clk = ~clk;

  // --------------------------------------------------------------
  // bus and compare helpers
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle write strobe; the next access leaves one idle edge
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    v = regRdata;
  endtask
  task automatic waitIrq();
    for (int i = 0; i < 300 && irq !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic waitPad(input int k, input logic lvl);
    for (int i = 0; i < 300 && padLevel[k] !== lvl; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  // program channel 0, restart timer 1 and arm with a fresh event time
  task automatic hit0(input logic [15:0] ctl);
    wr(ccpo_pkg::ADDR_CTL0, ctl);
    wr(ccpo_pkg::ADDR_TMR1, 16'h0);
    wr(ccpo_pkg::ADDR_TIME0, 16'h8);
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    logic [3:0] al[6] = '{4'h0, 4'h3, 4'h7, 4'hc, 4'he, 4'hf};
    foreach (al[i]) begin
      rd(al[i], d);
      check("reset or unmapped read", d, ccpo_pkg::RST_WORD);
    end
    check("pins after reset", {11'h0, irq, chanPin}, 16'h0);
    $display("test reset done");
  endtask
  task automatic t_actions();
    ccpo_pkg::ccpo_act_e acts[4] = '{ccpo_pkg::ACT_HIGH, ccpo_pkg::ACT_LOW,
      ccpo_pkg::ACT_TOGGLE, ccpo_pkg::ACT_TOGGLE};
    logic exp[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(ccpo_pkg::ADDR_MASK, 16'h0);
    wr(ccpo_pkg::ADDR_TCTL1, 16'h00c0);
    hit0(16'h0060);
    waitPad(0, 1'b1);
    check("masked irq", {15'h0, irq}, 16'h0);
    wr(ccpo_pkg::ADDR_MASK, 16'h000f);
    #1;
    check("unmasked irq", {15'h0, irq}, 16'h1);
    rd(ccpo_pkg::ADDR_STAT, d);
    check("status after hit", d, 16'h1);
    check("irq after status read", {15'h0, irq}, 16'h0);
    foreach (acts[i]) begin
      hit0(16'h0040 | (16'(acts[i]) << 4));
      waitIrq();
      check("action pin", {15'h0, chanPin[0]}, {15'h0, exp[i]});
      rd(ccpo_pkg::ADDR_STAT, d);
    end
    hit0(16'h0040);
    waitIrq();
    check("no action pin", {15'h0, chanPin[0]}, 16'h0);
    rd(ccpo_pkg::ADDR_STAT, d);
    // single shot: rerunning the timer past the time must not act again
    wr(ccpo_pkg::ADDR_TMR1, 16'h0);
    repeat (40) @(posedge clk);
    rd(ccpo_pkg::ADDR_STAT, d);
    check("disarmed status", d, 16'h0);
    wr(ccpo_pkg::ADDR_TIME0, 16'h1c);
    waitIrq();
    check("rearmed irq", {15'h0, irq}, 16'h1);
    rd(ccpo_pkg::ADDR_STAT, d);
    hit0(16'h0020);
    repeat (40) @(posedge clk);
    rd(ccpo_pkg::ADDR_STAT, d);
    check("capture mode no compare", d, 16'h0);
    $display("test actions done");
  endtask
  task automatic t_repeat();
    logic p = 1'b0;
    // prescale by two so the spacing check sees a stretched step
    wr(ccpo_pkg::ADDR_TCTL1, 16'h00c1);
    hit0(16'h0079);
    for (int k = 0; k < 3; k++) begin
      waitIrq();
      p = ~p;
      check("repeat toggle pin", {15'h0, chanPin[0]}, {15'h0, p});
      rd(ccpo_pkg::ADDR_STAT, d);
      check("one event per match", d, 16'h1);
      check("irq cleared", {15'h0, irq}, 16'h0);
    end
    // one match period is eight counts of two base steps each
    check("event spacing", lastHigh[0], 16'h10 * BC);
    wr(ccpo_pkg::ADDR_CTL0, 16'h0);
    wr(ccpo_pkg::ADDR_TCTL1, 16'h00c0);
    rd(ccpo_pkg::ADDR_STAT, d);
    $display("test repeat done");
  endtask
  task automatic t_pair();
    wr(ccpo_pkg::ADDR_PERIOD, 16'h0100);
    // restart the timer first so a stale armed time cannot match early
    wr(ccpo_pkg::ADDR_TMR1, 16'h0);
    wr(ccpo_pkg::ADDR_CTL0, 16'h0068);
    wr(4'h1, 16'h0158);
    wr(ccpo_pkg::ADDR_TIME0, 16'h10);
    wr(4'h5, 16'h11);
    waitPad(1, 1'b1);
    waitPad(1, 1'b0);
    // the meter latches the width one edge after the fall
    @(posedge clk);
    #1;
    check("pin0 unused when paired", {15'h0, padLevel[0]}, 16'h0);
    check("one count pulse", lastHigh[1], BC);
    rd(ccpo_pkg::ADDR_TIME0, d);
    check("server set time", d, 16'h0110);
    rd(4'h5, d);
    check("server clear time", d, 16'h0111);
    wr(ccpo_pkg::ADDR_CTL0, 16'h0);
    wr(4'h1, 16'h0);
    wr(ccpo_pkg::ADDR_PERIOD, 16'h0);
    rd(ccpo_pkg::ADDR_STAT, d);
    $display("test pair done");
  endtask
  task automatic t_fast();
    wr(4'h2, 16'h0078);
    wr(4'h3, 16'h0179);
    wr(ccpo_pkg::ADDR_TMR1, 16'h0);
    wr(4'h6, 16'h3);
    wr(4'h7, 16'h7);
    for (int i = 0; i < 400 && riseCount[3] < 16'h3; i++) begin
      @(posedge clk);
      #1;
    end
    check("pwm restarts", {15'h0, riseCount[3] >= 16'h3}, 16'h1);
    check("pwm high width", lastHigh[3], 16'h4 * BC);
    wr(4'h2, 16'h0);
    wr(4'h3, 16'h0);
    rd(ccpo_pkg::ADDR_STAT, d);
    $display("test fast pwm done");
  endtask
  task automatic t_ext();
    wr(ccpo_pkg::ADDR_TCTL1, 16'h0);
    // both channels in compare so that the pin release is visible
    wr(ccpo_pkg::ADDR_CTL0, 16'h0040);
    wr(4'h1, 16'h0040);
    tTwoDir <= 1'b1;
    #1;
    check("pins driven before lending", {14'h0, chanPinEn[1:0]}, 16'h3);
    // up bit left clear: only the direction pin can make timer two count up
    wr(TCTL2, 16'h0098);
    #1;
    check("pin0 drive off", {15'h0, chanPinEn[0]}, 16'h0);
    check("pin1 drive off", {15'h0, chanPinEn[1]}, 16'h0);
    wr(4'h2, 16'h00e0);
    wr(TMR2, 16'h0);
    wr(4'h6, 16'h3);
    for (int k = 0; k < 4; k++) begin
      repeat (4) @(posedge clk);
      tTwoClk <= 1'b1;
      repeat (4) @(posedge clk);
      tTwoClk <= 1'b0;
    end
    waitIrq();
    check("timer two reference", {15'h0, chanPin[2]}, 16'h1);
    $display("test timer two done");
  endtask

  // --------------------------------------------------------------
  // verdict
  // --------------------------------------------------------------
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog sized well above the sum of all scenarios
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("watchdog expired");
    results();
  end

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_actions();
    t_repeat();
    t_pair();
    t_fast();
    t_ext();
    results();
  end
endmodule
